// ==== logic/pattern_tester.sv ====
// What this block does
// RULE_01 - size, direction, verify enable and pattern select live in local registers
// RULE_02 - a software launch request makes a start pulse exactly one cycle long; the code makes it only when the same write leaves the direction bit clear
// RULE_03 - the cycle after the start pulse, the write-active flag is set
// RULE_04 - push outbound only while write-active and the queue is not nearly full
// RULE_05 - nearly full drops the push enable, pausing generation until it clears
// RULE_06 - every push advances the total write data counter
// RULE_07 - reaching the end count clears write-active and push together
// RULE_08 - pop inbound whenever not empty and compare each word with expected data
// RULE_09 - pop depends only on empty, not on start or total count
// RULE_10 - each pop advances the read data counter; the pop of a block's last word also steps the header address counter
// RULE_11 - five patterns: zeros, ones, increment, decrement and LFSR
// RULE_12 - zeros and ones patterns are fixed on every bit with no header
// RULE_13 - the incrementing pattern comes from a 53-bit counter
// RULE_14 - decrementing data is the bitwise inverse of incrementing data
// RULE_15 - LFSR follows x^31 + x^21 + x + 1
// RULE_16 - four 32-bit LFSR steps are computed each cycle by look-ahead
// RULE_17 - each 512-byte block of the increment, decrement and LFSR patterns has a 64-bit header in dwords 0 and 1
// RULE_18 - header is the 512-byte address, from a user start value, stepped per block
// RULE_19 - a popped word that differs from expected data raises the fail flag
// RULE_20 - runs on the queue clock at the queue's 128-bit width
// RULE_21 - each data queue is 512 deep and 128 bits wide
// RULE_22 - with verify disabled, data is still popped but fail never rises
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pattern_tester_cfg.svh"
module pattern_tester
#(
  parameter int QUEUE_DEPTH = 512, // see RULE_21
  parameter int DATA_WIDTH = 128
)
(
  input wire logic aclk, // see RULE_20
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic outbound_queue_nearly_full,
  output pattern_tester_pkg::outbound_type outbound_data_queue,
  input wire pattern_tester_pkg::inbound_type inbound_data_queue,
  output logic inbound_queue_pop,
  output logic write_run_launch_pulse,
  output logic write_transfer_active,
  output logic verify_fail
);
  import pattern_tester_pkg::*;

  state_type q, d;
  logic inbound_pop;
  logic [127:0] rd_expect;
  logic rd_last;

  // one lfsr step for x^31 + x^21 + x + 1, shift left with feedback into bit 0
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    lfsr_step = {s[30:0], s[30] ^ s[20] ^ s[0]}; // see RULE_15
  endfunction

  // build a 128-bit word for the given pattern and position in the block
  function automatic logic [127:0] make_word(input pattern_type p, input logic [4:0] word,
    input logic [63:0] addr, input logic [52:0] inc, input logic [31:0] lf);
    logic [127:0] w;
    logic [31:0] l1, l2, l3;
    w = '0;
    l1 = lfsr_step(lf);
    l2 = lfsr_step(l1);
    l3 = lfsr_step(l2);
    case (p)
      patt_zero: w = {128{1'b0}}; // see RULE_12
      patt_one: w = {128{1'b1}}; // see RULE_12
      patt_inc: w = {inc[31:0] + 32'h3, inc[31:0] + 32'h2, inc[31:0] + 32'h1, inc[31:0]};
      patt_dec: w = ~{inc[31:0] + 32'h3, inc[31:0] + 32'h2, inc[31:0] + 32'h1,
        inc[31:0]}; // see RULE_14
      patt_lfsr: w = {l3, l2, l1, lf}; // see RULE_16
      default: w = '0;
    endcase
    // header replaces dwords 0 and 1 of the first word of each block
    if (p != patt_zero && p != patt_one && word == 5'd0)
    begin
      w[63:0] = addr; // see RULE_17
    end
    return w;
  endfunction

  // next lfsr state advances four steps per word
  function automatic logic [31:0] lfsr_next4(input logic [31:0] s);
    lfsr_next4 = lfsr_step(lfsr_step(lfsr_step(lfsr_step(s)))); // see RULE_16
  endfunction

  // pop is never gated by start or count, only by empty
  assign inbound_pop = ~inbound_data_queue.empty; // see RULE_09
  assign rd_expect = make_word(q.patt, q.rd_word, q.rd_addr, q.rd_inc, q.rd_lfsr);
  assign rd_last = (q.rd_word == `WORDS_PER_BLOCK);

  // next state of bus slave, parameters and both generators
  always_comb
  begin
    logic [31:0] wval;
    logic [127:0] gen;
    logic wr_last;
    wval = 32'h0;
    d = q;
    d.launch = 1'b0; // see RULE_02
    wr_last = (q.wr_word == `WORDS_PER_BLOCK);
    gen = make_word(q.patt, q.wr_word, q.wr_addr, q.wr_inc, q.wr_lfsr);

    // bus slave: address and data taken in either order
    case (q.bus)
      bus_idle:
      begin
        if (s_axi_awvalid && !q.awdone)
        begin
          d.awdone = 1'b1;
          d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wdone)
        begin
          d.wdone = 1'b1;
          d.wdata = s_axi_wdata;
          d.wstrb = s_axi_wstrb;
        end
        if (q.awdone && q.wdone)
        begin
          d.bus = bus_wresp;
          d.awdone = 1'b0;
          d.wdone = 1'b0;
          d.resp = 2'b00;
          wval = q.wdata;
          if (q.awaddr == `OFS_CONTROL && q.wstrb[0])
          begin
            d.dir_read = wval[`CTL_DIR_BIT]; // see RULE_01
            d.verify = wval[`CTL_VERIFY_BIT];
            d.patt = pattern_type'(wval[`CTL_PATT_LSB +: 3]); // see RULE_11
            d.launch = wval[`CTL_LAUNCH_BIT] & ~wval[`CTL_DIR_BIT]; // see RULE_02
            if (wval[`CTL_CLEAR_FAIL_BIT] && q.wstrb[1])
            begin
              d.fail = 1'b0;
            end
            // arm both generators for a new run
            d.wr_count = 32'h0;
            d.rd_count = 32'h0;
            d.wr_word = 5'd0;
            d.rd_word = 5'd0;
            d.wr_addr = q.start_addr;
            d.rd_addr = q.start_addr;
            d.wr_inc = 53'h0;
            d.rd_inc = 53'h0;
            d.wr_lfsr = `RST_LFSR_SEED;
            d.rd_lfsr = `RST_LFSR_SEED;
          end
          else if (q.awaddr == `OFS_END_SIZE && q.wstrb == 4'hf)
          begin
            d.end_size = wval; // see RULE_01
          end
          else if (q.awaddr == `OFS_START_ADDR_LO && q.wstrb == 4'hf)
          begin
            d.start_addr[31:0] = wval; // see RULE_18
          end
          else if (q.awaddr == `OFS_START_ADDR_HI && q.wstrb == 4'hf)
          begin
            d.start_addr[63:32] = wval;
          end
          else if (q.awaddr == `OFS_STATUS || q.awaddr == `OFS_READ_COUNT ||
                   q.awaddr == `OFS_WRITE_COUNT)
          begin
            d.resp = 2'b00; // read-only, write ignored
          end
          else
          begin
            d.resp = 2'b10;
          end
        end
        else if (s_axi_arvalid && !q.awdone && !q.wdone)
        begin
          d.bus = bus_rresp;
          d.resp = 2'b00;
          if (s_axi_araddr == `OFS_CONTROL)
          begin
            // pattern sits at bits 6:4, bit 3 is unused
            d.rdata = {25'h0, q.patt, 1'b0, q.verify, q.dir_read, 1'b0};
          end
          else if (s_axi_araddr == `OFS_END_SIZE)
          begin
            d.rdata = q.end_size;
          end
          else if (s_axi_araddr == `OFS_START_ADDR_LO)
          begin
            d.rdata = q.start_addr[31:0];
          end
          else if (s_axi_araddr == `OFS_START_ADDR_HI)
          begin
            d.rdata = q.start_addr[63:32];
          end
          else if (s_axi_araddr == `OFS_STATUS)
          begin
            d.rdata = {30'h0, q.fail, q.write_active};
          end
          else if (s_axi_araddr == `OFS_READ_COUNT)
          begin
            d.rdata = q.rd_count;
          end
          else if (s_axi_araddr == `OFS_WRITE_COUNT)
          begin
            d.rdata = q.wr_count;
          end
          else
          begin
            d.rdata = 32'h0;
            d.resp = 2'b10;
          end
        end
      end
      bus_wresp:
      begin
        if (s_axi_bready)
        begin
          d.bus = bus_idle;
        end
      end
      bus_rresp:
      begin
        if (s_axi_rready)
        begin
          d.bus = bus_idle;
        end
      end
      default: d.bus = bus_idle;
    endcase

    // write flow: active flag follows the launch pulse by one cycle
    if (q.launch)
    begin
      d.write_active = 1'b1; // see RULE_03
    end
    d.push = 1'b0;
    if (q.write_active && !q.launch)
    begin
      if (q.wr_count == q.end_size)
      begin
        d.write_active = 1'b0; // see RULE_07
        d.push = 1'b0;
      end
      else if (!outbound_queue_nearly_full)
      begin
        d.push = 1'b1; // see RULE_04
        d.push_data = gen;
      end
      else
      begin
        d.push = 1'b0; // see RULE_05
      end
    end
    // counters advance with every registered push
    if (d.push)
    begin
      d.wr_count = q.wr_count + 32'h1; // see RULE_06
      d.wr_word = q.wr_word + 5'd1;
      d.wr_inc = q.wr_inc + 53'h4; // see RULE_13
      d.wr_lfsr = lfsr_next4(q.wr_lfsr);
      if (wr_last)
      begin
        d.wr_addr = q.wr_addr + 64'h1; // see RULE_18
      end
    end

    // read flow: every pop advances counters and is checked only while verify is set
    if (inbound_pop)
    begin
      d.rd_count = q.rd_count + 32'h1; // see RULE_10
      d.rd_word = q.rd_word + 5'd1;
      d.rd_inc = q.rd_inc + 53'h4;
      d.rd_lfsr = lfsr_next4(q.rd_lfsr);
      if (rd_last)
      begin
        d.rd_addr = q.rd_addr + 64'h1; // see RULE_10
      end
      // set wins over a clear in the same cycle
      if (q.verify && inbound_data_queue.data != rd_expect)
      begin
        d.fail = 1'b1; // see RULE_19 see RULE_22
      end
    end
  end

  // single state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.end_size <= `RST_END_SIZE;
      q.wr_lfsr <= `RST_LFSR_SEED;
      q.rd_lfsr <= `RST_LFSR_SEED;
    end
    else
    begin
      q <= d;
    end
  end

  // handshake outputs from state, data from flip-flops
  assign s_axi_awready = (q.bus == bus_idle) && !q.awdone;
  assign s_axi_wready = (q.bus == bus_idle) && !q.wdone;
  assign s_axi_bvalid = (q.bus == bus_wresp);
  assign s_axi_bresp = q.resp;
  assign s_axi_arready = (q.bus == bus_idle) && !q.awdone && !q.wdone;
  assign s_axi_rvalid = (q.bus == bus_rresp);
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.resp;
  assign outbound_data_queue.push = q.push;
  assign outbound_data_queue.data = q.push_data;
  assign inbound_queue_pop = inbound_pop; // see RULE_08
  assign write_run_launch_pulse = q.launch;
  assign write_transfer_active = q.write_active;
  assign verify_fail = q.fail;

  // launch stands one cycle only
  launch_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
    q.launch |=> !q.launch) else $error("launch longer than one cycle");
  active_follows_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_03
    q.launch |=> q.write_active) else $error("active not set after launch");
  push_gated_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_04
    q.push |-> $past(q.write_active) && !$past(outbound_queue_nearly_full))
    else $error("push without active or with nearly full");
  pause_full_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_05
    outbound_queue_nearly_full |=> !q.push) else $error("push during nearly full");
  count_push_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_06
    q.push && !$past(q.launch, 2) |-> q.wr_count == $past(q.wr_count) + 32'h1)
    else $error("write count not stepped by push");
  end_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
    q.write_active && !q.launch && q.wr_count == q.end_size && q.bus == bus_idle
    && !(q.awdone && q.wdone) |=> !q.write_active && !q.push)
    else $error("run did not stop at end count");
  pop_empty_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_09
    inbound_queue_pop == !inbound_data_queue.empty) else $error("pop not tied to empty");
  fail_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_19
    inbound_pop && q.verify && inbound_data_queue.data != rd_expect |=> q.fail)
    else $error("mismatch did not raise fail");
  // with verify off nothing may raise the flag, whatever the bus is doing
  no_verify_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_22
    !q.verify && !q.fail |=> !q.fail) else $error("fail rose with verify off");
  dec_inverse_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_14
    q.push && q.patt == patt_dec && q.wr_word != 5'd1 |-> q.push_data[127:96] ==
    ~($past(q.wr_inc[31:0]) + 32'h3)) else $error("decrement not inverse");

  // a pushed word was built from the generator state of the cycle before the push
  fixed_patt_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_12
    q.push && ($past(q.patt) == patt_zero || $past(q.patt) == patt_one)
    |-> q.push_data == {128{$past(q.patt[0])}}) else $error("fixed pattern not constant");
  header_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_17
    q.push && $past(q.wr_word) == 5'd0 && $past(q.patt) inside {patt_inc, patt_dec, patt_lfsr}
    |-> q.push_data[63:0] == $past(q.wr_addr)) else $error("block header missing");
  block_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_18
    q.push && $past(q.wr_word) == `WORDS_PER_BLOCK |-> q.wr_addr == $past(q.wr_addr) + 64'h1)
    else $error("address not stepped after block");
  read_step_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_10
    inbound_pop |=> q.rd_count == $past(q.rd_count) + 32'h1)
    else $error("read count not stepped by pop");

  // a launch, then in the very next cycle an active run with room in the queue
  sequence run_open_seq;
    q.launch ##1 (q.write_active && !outbound_queue_nearly_full && q.wr_count != q.end_size);
  endsequence
  first_push_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_04
    run_open_seq |=> q.push) else $error("no push once the run opened");
endmodule // pattern_tester

// ==== common/pattern_tester_cfg.svh ====
`ifndef PATTERN_TESTER_CFG_SVH
`define PATTERN_TESTER_CFG_SVH
// register byte offsets on the AXI4-Lite slave
`define OFS_CONTROL 12'h000
`define OFS_END_SIZE 12'h004
`define OFS_START_ADDR_LO 12'h008
`define OFS_START_ADDR_HI 12'h00c
`define OFS_STATUS 12'h010
`define OFS_READ_COUNT 12'h014
`define OFS_WRITE_COUNT 12'h018
// control register field positions
`define CTL_LAUNCH_BIT 0
`define CTL_DIR_BIT 1
`define CTL_VERIFY_BIT 2
`define CTL_PATT_LSB 4
`define CTL_CLEAR_FAIL_BIT 8
// status register field positions
`define STS_ACTIVE_BIT 0
`define STS_FAIL_BIT 1
// reset values
`define RST_END_SIZE 32'h0000_0000
`define RST_LFSR_SEED 32'h0000_0001
// index of the last 128-bit word in a 512-byte block
`define WORDS_PER_BLOCK 5'd31
`endif

// ==== common/pattern_tester_pkg.sv ====
package pattern_tester_pkg;
  typedef enum logic [2:0]
  {
    patt_zero = 3'b000,
    patt_one = 3'b001,
    patt_inc = 3'b010,
    patt_dec = 3'b011,
    patt_lfsr = 3'b100
  } pattern_type;

  typedef enum logic [1:0]
  {
    bus_idle = 2'b00,
    bus_wresp = 2'b01,
    bus_rresp = 2'b10
  } bus_state_type;

  // outbound queue push side
  typedef struct packed
  {
    logic push;
    logic [127:0] data;
  } outbound_type;

  // inbound queue pop side
  typedef struct packed
  {
    logic empty;
    logic [127:0] data;
  } inbound_type;

  typedef struct packed
  {
    bus_state_type bus;
    logic awdone;
    logic wdone;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic launch;
    logic dir_read;
    logic verify;
    pattern_type patt;
    logic [31:0] end_size;
    logic [63:0] start_addr;
    logic write_active;
    logic push;
    logic [127:0] push_data;
    logic [31:0] wr_count;
    logic [31:0] rd_count;
    logic [4:0] wr_word;
    logic [4:0] rd_word;
    logic [63:0] wr_addr;
    logic [63:0] rd_addr;
    logic [52:0] wr_inc;
    logic [52:0] rd_inc;
    logic [31:0] wr_lfsr;
    logic [31:0] rd_lfsr;
    logic fail;
  } state_type;
endpackage

// ==== bench/queue_model.sv ====
`timescale 1ns/1ps
module queue_model
#(
  parameter int DEPTH = 512
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire pattern_tester_pkg::outbound_type outbound,
  output logic nearly_full,
  input wire logic pop,
  input wire logic load_valid,
  input wire logic [127:0] load_data,
  output pattern_tester_pkg::inbound_type inbound
);
  import pattern_tester_pkg::*;
  int fill;
  logic [127:0] q[$];

  // the host side drains one word a cycle unless it stalls
  always @(posedge aclk)
  begin
    if (!aresetn)
      fill <= 0;
    else
      fill <= fill + int'(outbound.push) - int'(!stall && fill > 0);
  end

  // threshold leaves slack for the one-cycle push latency
  assign nearly_full = stall || fill >= DEPTH - 8;

  initial inbound = '{empty: 1'b1, data: '0};

  // show-ahead read side; an empty queue shows the stale word and its inverse on alternate cycles
  always @(posedge aclk)
  begin
    if (!aresetn)
      q.delete();
    else
    begin
      if (pop && q.size() > 0)
        void'(q.pop_front());
      if (load_valid && q.size() < DEPTH)
        q.push_back(load_data);
    end
    inbound.empty <= (q.size() == 0);
    inbound.data <= (q.size() > 0) ? q[0] : ~inbound.data;
  end
endmodule // queue_model

// ==== bench/pattern_tester_tb.sv ====
`timescale 1ns/1ps
`include "pattern_tester_cfg.svh"
module pattern_tester_tb;
  import pattern_tester_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, load_valid = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rng = 32'h0000f0e6, d, n;
  logic [1:0] r;
  logic [127:0] load_data = '0;
  logic outbound_queue_nearly_full, inbound_queue_pop, write_run_launch_pulse;
  logic write_transfer_active, verify_fail, nf_q = 1'b0, launch_q = 1'b0;
  outbound_type outbound_data_queue;
  inbound_type inbound_data_queue;
  logic [2:0] cur_p = 3'h0;
  logic [63:0] cur_a = 64'h0;
  int fails = 0, checks = 0, pushes = 0, k;

  pattern_tester dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .outbound_queue_nearly_full, .outbound_data_queue,
    .inbound_data_queue, .inbound_queue_pop, .write_run_launch_pulse, .write_transfer_active,
    .verify_fail);

  queue_model host (.aclk, .aresetn, .stall, .outbound(outbound_data_queue),
    .nearly_full(outbound_queue_nearly_full), .pop(inbound_queue_pop), .load_valid,
    .load_data, .inbound(inbound_data_queue));

  always #12.5 aclk = ~aclk;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // expected word n of a run; the lfsr is replayed from its seed each time, slow but plain
  function automatic logic [127:0] gen(input logic [2:0] p, input int n, input logic [63:0] a);
    logic [127:0] w;
    logic [31:0] s;
    s = 32'h1;
    repeat (4 * n) s = {s[30:0], s[30] ^ s[20] ^ s[0]};
    for (int i = 0; i < 4; i++)
    begin
      w[32*i+:32] = (p == 3'h4) ? s : 32'(4 * n + i);
      s = {s[30:0], s[30] ^ s[20] ^ s[0]};
    end
    if (p == 3'h3)
      w = ~w;
    if (p < 3'h2)
      return {128{p[0]}};
    if (n % 32 == 0)
      w[63:0] = a + 64'(n / 32);
    return w;
  endfunction

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end
    while (!(s_axi_bvalid && s_axi_bready) && t < 100);
    chk("bresp", s_axi_bresp, 2'h0);
    s_axi_bready <= 1'b0;
    if (t >= 100) fails++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end
    while (!(s_axi_rvalid && s_axi_rready) && t < 100);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (t >= 100) fails++;
  endtask

  // hands one word to the inbound queue after random gaps, then drops load_valid on the next edge
  task automatic feed(input logic [127:0] w);
    logic g;
    g = 1'b0;
    while (!g)
    begin
      @(posedge aclk);
      g = (xs() % 32'h2) != 32'h0;
      load_valid <= g;
      load_data <= w;
    end
    @(posedge aclk);
    load_valid <= 1'b0;
  endtask

  task automatic drain();
    k = 0;
    // the last load shows up on empty only after this edge
    @(posedge aclk);
    while (!inbound_data_queue.empty && k < 200)
    begin
      @(posedge aclk);
      k++;
    end
  endtask

  // watches the stream side every edge; stall is redrawn here so pauses hit any cycle
  always @(posedge aclk)
  begin
    chk("pop", inbound_queue_pop, !inbound_data_queue.empty);
    if (aresetn && outbound_data_queue.push)
    begin
      chk("push_gap", nf_q, 1'b0);
      chk("push_data", outbound_data_queue.data, gen(cur_p, pushes, cur_a));
      pushes++;
    end
    if (aresetn && launch_q)
    begin
      chk("active", write_transfer_active, 1'b1);
      chk("pulse", write_run_launch_pulse, 1'b0);
    end
    nf_q = outbound_queue_nearly_full;
    launch_q = write_run_launch_pulse;
    stall <= (xs() % 32'h4) == 32'h0;
  end

  initial
  begin
    #(25ns * 40000);
    fails++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_STATUS, d, r);
    chk("status_reset", d, 32'h0);
    rd(12'h0fc, d, r);
    chk("unmapped_resp", r, 2'h2);
    wr(`OFS_END_SIZE, 32'h0000005a);
    rd(`OFS_END_SIZE, d, r);
    chk("end_size", d, 32'h0000005a);
    // every pattern; sizes straddle the 32-word block edge so the increment, decrement and LFSR runs show a second header
    for (int p = 0; p < 5; p++)
    begin
      cur_p = 3'(p);
      cur_a = {xs(), xs()};
      n = 32'(33 + 2 * p);
      wr(`OFS_START_ADDR_LO, cur_a[31:0]);
      wr(`OFS_START_ADDR_HI, cur_a[63:32]);
      wr(`OFS_END_SIZE, n);
      pushes = 0;
      wr(`OFS_CONTROL, 32'h00000001 | (32'(p) << 4));
      k = 0;
      while ((pushes < n || write_transfer_active) && k < 3000)
      begin
        @(posedge aclk);
        k++;
      end
      repeat (4) @(posedge aclk);
      chk("push_count", pushes, n);
      rd(`OFS_WRITE_COUNT, d, r);
      chk("write_count", d, n);
      wr(`OFS_CONTROL, 32'h00000106 | (32'(p) << 4));
      for (int i = 0; i < n; i++)
        feed(gen(cur_p, i, cur_a));
      drain();
      rd(`OFS_STATUS, d, r);
      chk("fail_clean", d[`STS_FAIL_BIT], 1'b0);
      rd(`OFS_READ_COUNT, d, r);
      chk("read_count", d, n);
      feed(gen(cur_p, n, cur_a) ^ 128'h1);
      drain();
      rd(`OFS_STATUS, d, r);
      chk("fail_set", d[`STS_FAIL_BIT], 1'b1);
      chk("fail_pin", verify_fail, 1'b1);
      wr(`OFS_CONTROL, 32'h00000102 | (32'(p) << 4));
      feed(gen(cur_p, 0, cur_a) ^ 128'h1);
      drain();
      rd(`OFS_STATUS, d, r);
      chk("fail_off", d[`STS_FAIL_BIT], 1'b0);
      rd(`OFS_READ_COUNT, d, r);
      chk("pop_no_verify", d, 32'h1);
    end
    close_out();
  end
endmodule // pattern_tester_tb
